// *** core/wdt_pkg.sv ***
// Constants, types and helpers shared by the watchdog design files
// Behaviour
// - Period selectable 1 to 512 seconds, power-of-two
// - Count down, act on reaching zero
// - Restart reloads full period; software restarts before expiry
// - Expiry gives exactly one action: reset, NMI, IRQ
// - Disabled watchdog never produces an action
package wdt_pkg;
   localparam logic [7:0]  CTRL_OFS     = 8'h00;
   localparam logic [7:0]  RESTART_OFS  = 8'h04;
   localparam logic [7:0]  COUNT_OFS    = 8'h08;
   localparam logic [7:0]  STAT_OFS     = 8'h0c;
   localparam logic [7:0]  CLR_OFS      = 8'h10;
   localparam logic [7:0]  IEN_OFS      = 8'h14;

   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TICK_TIME_NS  = 1_000_000_000;
   localparam int unsigned TICK_CYC      = TICK_TIME_NS / CLK_PERIOD_NS;

   localparam int unsigned CNT_W        = 10;
   localparam logic [3:0]  PERIOD_MAX   = 4'h9;
   localparam int unsigned NUM_LINES    = 11;
   localparam logic [3:0]  LINE_MAX     = 4'ha;
   localparam logic [3:0]  IRQ_LINE [NUM_LINES] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9,
                                                    4'ha, 4'hb, 4'hc, 4'he, 4'hf};

   typedef enum logic [1:0] {
      ACT_RESET = 2'b00,
      ACT_NMI   = 2'b01,
      ACT_IRQ   = 2'b10,
      ACT_RSVD  = 2'b11
   } action_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_FIRED = 2'b10
   } wdt_state_t;

   // Control word: line index [10:7], action [6:5], period select [4:1], enable [0]
   typedef struct packed {
      logic [3:0] line;
      action_t    action;
      logic [3:0] period;
      logic       en;
   } ctrl_t;

   localparam ctrl_t CTRL_RST = '{line: 4'h0, action: ACT_RESET, period: 4'h0, en: 1'b0};

   typedef struct packed {
      logic [7:0]  addr;
      logic        write;
      logic [31:0] wdata;
   } apb_req_t;

   // Selects above nine stick at the longest period
   function automatic logic [CNT_W-1:0] period_of(input logic [3:0] sel);
      logic [3:0] s;
      s = (sel > PERIOD_MAX) ? PERIOD_MAX : sel;
      return CNT_W'(1) << s;
   endfunction
endpackage

// *** core/wdt_tick_gen.sv ***
// One-second tick prescaler for the watchdog countdown
`timescale 1ns/1ns
module wdt_tick_gen
   import wdt_pkg::*;
#(
   parameter int unsigned CYCLES = TICK_CYC
) (
   input  wire logic core_clk,  // System clock
   input  wire logic nrst,      // Async reset, active low
   input  wire logic clr,       // Restart the second from zero
   output logic      tick       // One-cycle pulse per second
);
   localparam int unsigned W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] cnt_r, cnt_nxt;
   logic         tick_nxt;

   always_comb begin
      tick_nxt = 1'b0;
      if (clr) begin
         cnt_nxt = '0;
      end else if (cnt_r == LAST) begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end else begin
         cnt_nxt = cnt_r + W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick  <= tick_nxt;
      end
   end
endmodule

// *** core/chipset_watchdog_timer.sv ***
// Watchdog countdown with APB registers, timeout actions and interrupt
`timescale 1ns/1ns
module chipset_watchdog_timer
   import wdt_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TICK_CYC
) (
   input  wire logic        core_clk,    // 10 MHz system clock
   input  wire logic        nrst,        // Async reset, active low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB access phase
   input  wire logic        pwrite,      // APB direction, high writes
   input  wire logic [7:0]  paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error on unmapped address
   output logic             sys_rst_out, // Timeout system reset request
   output logic             nmi_out,     // Timeout NMI request
   output logic      [15:0] isa_irq,     // Timeout interrupt lines
   output logic             wdt_irq      // Status interrupt, level
);
   apb_req_t       req;
   logic           setup, wr, restart;
   logic           tick, tick_clr;
   ctrl_t          ctrl_r, ctrl_nxt;
   wdt_state_t     st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   action_t        act_r, act_nxt;
   logic [3:0]     line_r, line_nxt;
   logic           stat_r, stat_nxt, ien_r, ien_nxt;
   logic [31:0]    prdata_nxt;
   logic           pslverr_nxt;
   logic           rst_nxt, nmi_nxt, irq_nxt;
   logic [15:0]    isa_nxt;

   assign req     = '{addr: paddr, write: pwrite, wdata: pwdata};
   assign setup   = psel && !penable;
   // Zero-wait slave: pready is high from the first edge after reset
   assign wr      = psel && penable && pready && req.write;
   assign restart = wr && (req.addr == RESTART_OFS);

   wdt_tick_gen #(
      .CYCLES (TICK_CYCLES)
   ) u_tick (
      .core_clk (core_clk),
      .nrst     (nrst),
      .clr      (tick_clr),
      .tick     (tick)
   );

   // Registers and bus answers
   always_comb begin
      ctrl_nxt    = ctrl_r;
      ien_nxt     = ien_r;
      prdata_nxt  = prdata;
      pslverr_nxt = 1'b0;
      if (wr && req.addr == CTRL_OFS) begin
         ctrl_nxt = ctrl_t'(req.wdata[10:0]);
      end
      if (wr && req.addr == IEN_OFS) begin
         ien_nxt = req.wdata[0];
      end
      if (setup) begin
         prdata_nxt = 32'h0;
         case (req.addr)
            CTRL_OFS:    prdata_nxt = {21'h0, ctrl_r};
            RESTART_OFS: prdata_nxt = 32'h0;
            COUNT_OFS:   prdata_nxt = {20'h0, st_r, cnt_r};
            STAT_OFS:    prdata_nxt = {31'h0, stat_r};
            CLR_OFS:     prdata_nxt = 32'h0;
            IEN_OFS:     prdata_nxt = {31'h0, ien_r};
            default:     pslverr_nxt = 1'b1;
         endcase
      end else if (psel && penable) begin
         pslverr_nxt = pslverr;
      end
   end

   // Countdown state machine
   always_comb begin
      st_nxt   = st_r;
      cnt_nxt  = cnt_r;
      act_nxt  = act_r;
      line_nxt = line_r;
      tick_clr = 1'b0;
      case (st_r)
         ST_IDLE: begin
            if (ctrl_r.en) begin
               cnt_nxt  = period_of(ctrl_r.period);
               tick_clr = 1'b1;
               st_nxt   = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!ctrl_r.en) begin
               st_nxt = ST_IDLE;
            end else if (restart) begin
               cnt_nxt  = period_of(ctrl_r.period);
               tick_clr = 1'b1;
            end else if (tick) begin
               cnt_nxt = cnt_r - CNT_W'(1);
               if (cnt_r == CNT_W'(1)) begin
                  st_nxt   = ST_FIRED;
                  act_nxt  = ctrl_r.action;  // Latched so one action holds
                  line_nxt = (ctrl_r.line > LINE_MAX) ? LINE_MAX : ctrl_r.line;
               end
            end
         end
         ST_FIRED: begin
            if (!ctrl_r.en) begin
               st_nxt = ST_IDLE;
            end else if (restart) begin
               cnt_nxt  = period_of(ctrl_r.period);
               tick_clr = 1'b1;
               st_nxt   = ST_RUN;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
   end

   // Action outputs follow the next state so they line up with st_r
   always_comb begin
      rst_nxt = 1'b0;
      nmi_nxt = 1'b0;
      irq_nxt = 1'b0;
      isa_nxt = 16'h0;
      if (st_nxt == ST_FIRED && ctrl_nxt.en) begin
         case (act_nxt)
            ACT_NMI: nmi_nxt = 1'b1;
            ACT_IRQ: irq_nxt = 1'b1;
            default: rst_nxt = 1'b1;
         endcase
      end
      for (int i = 0; i < NUM_LINES; i++) begin
         if (irq_nxt && line_nxt == 4'(i)) begin
            isa_nxt[IRQ_LINE[i]] = 1'b1;
         end
      end
   end

   // Sticky expiry flag; a fresh expiry wins over a clear
   always_comb begin
      stat_nxt = stat_r;
      if (wr && req.addr == CLR_OFS && req.wdata[0]) begin
         stat_nxt = 1'b0;
      end
      if (st_r == ST_RUN && st_nxt == ST_FIRED) begin
         stat_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r      <= CTRL_RST;
         ien_r       <= 1'b0;
         stat_r      <= 1'b0;
         st_r        <= ST_IDLE;
         cnt_r       <= '0;
         act_r       <= ACT_RESET;
         line_r      <= 4'h0;
         prdata      <= 32'h0;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         sys_rst_out <= 1'b0;
         nmi_out     <= 1'b0;
         isa_irq     <= 16'h0;
         wdt_irq     <= 1'b0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         ien_r       <= ien_nxt;
         stat_r      <= stat_nxt;
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         act_r       <= act_nxt;
         line_r      <= line_nxt;
         prdata      <= prdata_nxt;
         pready      <= 1'b1;
         pslverr     <= pslverr_nxt;
         sys_rst_out <= rst_nxt;
         nmi_out     <= nmi_nxt;
         isa_irq     <= isa_nxt;
         wdt_irq     <= stat_nxt && ien_nxt;
      end
   end

   property p_load_period;
      @(posedge core_clk) disable iff (!nrst)
      (st_r == ST_IDLE && ctrl_r.en) |=> (cnt_r == period_of($past(ctrl_r.period)));
   endproperty
   a_load_period: assert property (p_load_period) else $error("period not loaded");

   property p_decrement;
      @(posedge core_clk) disable iff (!nrst)
      (st_r == ST_RUN && ctrl_r.en && !restart && tick && cnt_r > CNT_W'(1))
         |=> (cnt_r == $past(cnt_r) - CNT_W'(1)) && st_r == ST_RUN;
   endproperty
   a_decrement: assert property (p_decrement) else $error("count did not step");

   property p_expire;
      @(posedge core_clk) disable iff (!nrst)
      (st_r == ST_RUN && ctrl_r.en && !restart && tick && cnt_r == CNT_W'(1))
         |=> st_r == ST_FIRED && cnt_r == '0 && stat_r;
   endproperty
   a_expire: assert property (p_expire) else $error("no expiry at zero");

   property p_restart;
      @(posedge core_clk) disable iff (!nrst)
      (restart && ctrl_r.en && st_r != ST_IDLE)
         |=> st_r == ST_RUN && cnt_r == period_of($past(ctrl_r.period)) && !sys_rst_out;
   endproperty
   a_restart: assert property (p_restart) else $error("restart not reloaded");

   property p_one_action;
      @(posedge core_clk) disable iff (!nrst)
      $onehot0({sys_rst_out, nmi_out, isa_irq}) &&
      ((st_r == ST_FIRED && ctrl_r.en) == (sys_rst_out || nmi_out || (|isa_irq)));
   endproperty
   a_one_action: assert property (p_one_action) else $error("action count wrong");

   property p_disabled_quiet;
      @(posedge core_clk) disable iff (!nrst)
      !ctrl_r.en |=> !sys_rst_out && !nmi_out && isa_irq == 16'h0 && st_r == ST_IDLE;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("action while off");

   property p_tick_only;
      @(posedge core_clk) disable iff (!nrst)
      (st_r == ST_RUN && ctrl_r.en && !restart && !tick) |=> $stable(cnt_r);
   endproperty
   a_tick_only: assert property (p_tick_only) else $error("count moved off tick");

   c_fire_reset: cover property (@(posedge core_clk) disable iff (!nrst) $rose(sys_rst_out));
   c_fire_nmi:   cover property (@(posedge core_clk) disable iff (!nrst) $rose(nmi_out));
   c_fire_irq:   cover property (@(posedge core_clk) disable iff (!nrst) $rose(|isa_irq));
   c_restart:    cover property (@(posedge core_clk) disable iff (!nrst)
                                 restart && st_r == ST_RUN && cnt_r == CNT_W'(1));
endmodule

// *** tb/host_sink.sv ***
// Host-side model that counts timeout action requests
`timescale 1ns/1ns
module host_sink (
   input  wire logic        core_clk, // System clock
   input  wire logic        nrst,     // Async reset, active low
   input  wire logic [17:0] act,      // Reset, NMI and IRQ requests
   output int               events    // Rising requests seen
);
   logic [17:0] last;

   // A rise on any line is one host event; two at once still count once
   always @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         last   <= '0;
         events <= 0;
      end else begin
         last <= act;
         if ((act & ~last) != 18'h0) events <= events + 1;
      end
   end
endmodule

// *** tb/tb_chipset_watchdog_timer.sv ***
// Self-checking testbench for the watchdog with host model
`timescale 1ns/1ns
module tb_chipset_watchdog_timer;
   import wdt_pkg::*;
   localparam int TK = 20;
   logic        core_clk = 1'b0;
   logic        nrst     = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        err;
   logic        pready;
   logic        pslverr;
   logic        sys_rst_out;
   logic        nmi_out;
   logic [15:0] isa_irq;
   logic        wdt_irq;
   logic [17:0] act;
   int          events;
   int          bad_count = 0;
   int          checks = 0;

   assign act = {sys_rst_out, nmi_out, isa_irq};
   always #50 core_clk = ~core_clk;

   chipset_watchdog_timer #(.TICK_CYCLES(TK)) dut_u (.core_clk(core_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_rst_out(sys_rst_out),
      .nmi_out(nmi_out), .isa_irq(isa_irq), .wdt_irq(wdt_irq));
   host_sink host_u (.core_clk(core_clk), .nrst(nrst), .act(act), .events(events));

   task test_done;
      if (bad_count == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask

   task cyc(input int k);
      repeat (k) @(posedge core_clk);
      @(negedge core_clk);
   endtask

   // Waits on pready as long as it takes; only the bench timeout ends a hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task t_reset;
      // Pready only rises at the first edge after release
      cyc(1);
      chk("pready", 32'(pready), 32'h1);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk("ctrl rst", rd, 32'h0);
      apb(1'b1, COUNT_OFS, 32'h3ff);
      apb(1'b0, COUNT_OFS, 32'h0);
      chk("count ro", rd, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 32'(err), 32'h1);
   endtask

   task fire(input action_t ac, input logic [3:0] ln, input logic [3:0] sel,
             input logic [17:0] exp);
      int    p;
      int    e0;
      ctrl_t c;
      p  = 1 << sel;
      c  = '{line: ln, action: ac, period: sel, en: 1'b1};
      e0 = events;
      apb(1'b1, CTRL_OFS, 32'(c));
      apb(1'b0, COUNT_OFS, 32'h0);
      chk("count", rd, {20'h0, 2'b01, 10'(p)});
      cyc(p * TK - 6);
      chk("early", 32'(act), 32'h0);
      cyc(7);
      chk("action", 32'(act), 32'(exp));
      chk("events", 32'(events - e0), 32'h1);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("status", rd, 32'h1);
      apb(1'b1, CTRL_OFS, 32'h0);
      cyc(1);
      chk("off", 32'(act), 32'h0);
      apb(1'b1, CLR_OFS, 32'h1);
   endtask

   task t_actions;
      int lines[11];
      lines = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
      fire(ACT_RESET, 4'h0, 4'h0, 18'h20000);
      fire(ACT_RSVD, 4'h0, 4'h0, 18'h20000);
      fire(ACT_IRQ, 4'hf, 4'h0, 18'h08000);
      fire(ACT_NMI, 4'h0, 4'h1, 18'h10000);
      for (int i = 0; i < 11; i++) fire(ACT_IRQ, 4'(i), 4'h0, 18'(1) << lines[i]);
   endtask

   task t_restart;
      ctrl_t c;
      c = '{line: 4'h0, action: ACT_NMI, period: 4'h9, en: 1'b1};
      apb(1'b1, CTRL_OFS, 32'(c));
      apb(1'b0, COUNT_OFS, 32'h0);
      chk("max", rd, {20'h0, 2'b01, 10'd512});
      apb(1'b1, CTRL_OFS, 32'h0);
      c.period = 4'hf;
      apb(1'b1, CTRL_OFS, 32'(c));
      apb(1'b0, COUNT_OFS, 32'h0);
      chk("clamp", rd, {20'h0, 2'b01, 10'd512});
      apb(1'b1, CTRL_OFS, 32'h0);
      c.period = 4'h2;
      apb(1'b1, CTRL_OFS, 32'(c));
      cyc(60);
      apb(1'b1, RESTART_OFS, 32'h0);
      apb(1'b0, COUNT_OFS, 32'h0);
      chk("reload", rd, {20'h0, 2'b01, 10'd4});
      cyc(70);
      chk("held", 32'(act), 32'h0);
      cyc(12);
      chk("late", 32'(act), 32'h10000);
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, CLR_OFS, 32'h1);
   endtask

   task t_disable;
      ctrl_t c;
      c = '{line: 4'h0, action: ACT_RESET, period: 4'h0, en: 1'b1};
      apb(1'b1, CTRL_OFS, 32'(c));
      cyc(5);
      apb(1'b1, CTRL_OFS, 32'h0);
      cyc(40);
      chk("disabled", 32'(act), 32'h0);
      apb(1'b0, STAT_OFS, 32'h0);
      chk("no status", rd, 32'h0);
      apb(1'b1, RESTART_OFS, 32'h0);
      apb(1'b0, COUNT_OFS, 32'h0);
      // Idle keeps the stale count of one; state field must stay idle
      chk("idle", rd, 32'h1);
   endtask

   task t_irq;
      ctrl_t c;
      c = '{line: 4'h0, action: ACT_NMI, period: 4'h0, en: 1'b1};
      apb(1'b1, IEN_OFS, 32'h1);
      apb(1'b0, IEN_OFS, 32'h0);
      chk("ien", rd, 32'h1);
      apb(1'b1, CTRL_OFS, 32'(c));
      cyc(30);
      chk("irq on", 32'(wdt_irq), 32'h1);
      apb(1'b1, IEN_OFS, 32'h0);
      cyc(1);
      chk("masked", 32'(wdt_irq), 32'h0);
      apb(1'b1, IEN_OFS, 32'h1);
      cyc(1);
      chk("unmasked", 32'(wdt_irq), 32'h1);
      apb(1'b1, CTRL_OFS, 32'h0);
      apb(1'b1, CLR_OFS, 32'h1);
      cyc(1);
      chk("cleared", 32'(wdt_irq), 32'h0);
   endtask

   initial begin
      #2_000_000;
      bad_count++;
      test_done;
   end

   initial begin
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset;
      t_actions;
      t_restart;
      t_disable;
      t_irq;
      test_done;
   end
endmodule
